// [hdl/spm_master.sv]
// Master-only serial port top: frame sequencer, selects and clock
`timescale 1ns/100ps
`include "spm_cfg.svh"
module spm_master
   import spm_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [`SPM_DIV_W-1:0] clk_div_i,
   input wire logic [`SPM_LEN_W-1:0] char_len_i,
   input wire logic [`SPM_FRAME_W-1:0] frame_len_i,
   input wire logic [`SPM_SEL_W-1:0] slave_sel_i,
   input wire logic [`SPM_CS_N-1:0] select_pol_i,
   input wire logic clock_polarity_select_i,
   input wire logic clock_phase_select_i,
   input wire logic [`SPM_DLY_W-1:0] data_delay_i,
   input wire logic loopback_i,
   input wire logic char_irq_en_i,
   input wire logic [`SPM_DATA_W-1:0] tx_data_i,
   input wire logic serial_in_i,
   output logic serial_clk_o,
   output logic serial_out_o,
   output logic [`SPM_CS_N-1:0] slave_select_lines_o,
   output logic [`SPM_DATA_W-1:0] rx_data_o,
   output logic char_done_o,
   output logic char_irq_o,
   output logic frame_done_o,
   output logic busy_o
);
   // *****************************************************
   // Declarations
   // *****************************************************
   spm_state_t state;
   spm_state_t next_state;
   logic cpol;
   logic cpha;
   logic [`SPM_LEN_W-1:0] len;
   logic [`SPM_FRAME_W-1:0] frame_len;
   logic [`SPM_SEL_W-1:0] sel;
   logic [`SPM_CS_N-1:0] pol;
   logic [`SPM_DLY_W-1:0] delay;
   logic irq_en;
   logic loop;
   logic lvl;
   logic [`SPM_LEN_W-1:0] bit_cnt;
   logic [`SPM_FRAME_W-1:0] char_cnt;
   logic [`SPM_LEAD_W-1:0] lead_cnt;
   wire tick;
   wire take;
   wire in_shift;
   wire leading;
   wire trailing;
   wire do_shift;
   wire do_sample;
   wire char_end;
   wire more;
   wire lead_done;
   wire next_lvl;
   wire [`SPM_LEAD_W-1:0] lead_last;

   spm_shift_if sif ();

   // Drive level of all selects: chosen line active only when on is set, others inactive
   function automatic logic [`SPM_CS_N-1:0] cs_drive(input logic [`SPM_SEL_W-1:0] s,
                                                      input logic [`SPM_CS_N-1:0] p,
                                                      input logic on);
      logic [`SPM_CS_N-1:0] hit;
      hit = on ? (4'h1 << s) : 4'h0;
      cs_drive = ~(hit ^ p);
   endfunction

   // *****************************************************
   // Sub-blocks
   // *****************************************************
   spm_clk_div u_div (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .run_i(state != ST_IDLE),
      .div_i(clk_div_i),
      .tick_o(tick)
   );

   spm_shifter u_sh (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .sif(sif)
   );

   // *****************************************************
   // Edge and event decode
   // *****************************************************
   // Start is accepted only from idle; the port always leads the clock
   assign take = (state == ST_IDLE) && start_i;
   assign in_shift = tick && (state == ST_SHIFT);
   assign leading = in_shift && !lvl;
   assign trailing = in_shift && lvl;
   // Phase 0 samples on leading, phase 1 on trailing
   assign do_sample = cpha ? trailing : leading;
   assign do_shift = cpha ? (leading && (bit_cnt != 5'h00)) : trailing;
   assign char_end = trailing && (bit_cnt == len);
   assign more = (char_cnt != frame_len);
   assign lead_last = {delay, 1'b0};
   assign lead_done = tick && (state == ST_LEAD) && (lead_cnt == lead_last);
   assign next_lvl = in_shift ? !lvl : lvl;

   // Shift engine hookup
   assign sif.load = take || (char_end && more);
   assign sif.shift = do_shift;
   assign sif.sample = do_sample;
   assign sif.loopback = loop;
   assign sif.serial_in = serial_in_i;
   assign sif.load_data = tx_data_i;
   assign sif.char_len = take ? char_len_i : len;
   assign serial_out_o = sif.tx_msb;

   // *****************************************************
   // Frame sequencer
   // *****************************************************
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (start_i)
               next_state = ST_LEAD;
         ST_LEAD:
            if (lead_done)
               next_state = ST_SHIFT;
         ST_SHIFT:
            if (char_end && !more)
               next_state = ST_TRAIL;
         ST_TRAIL:
            if (tick)
               next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // Frame settings other than the clock divider held steady for the whole frame
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         {cpol, cpha, irq_en, loop} <= 4'h0;
         len <= '0;
         frame_len <= '0;
         sel <= '0;
         pol <= '0;
         delay <= '0;
      end
      else if (take)
      begin
         {cpol, cpha, irq_en, loop} <= {clock_polarity_select_i, clock_phase_select_i,
                                        char_irq_en_i, loopback_i};
         len <= char_len_i;
         frame_len <= frame_len_i;
         sel <= slave_sel_i;
         pol <= select_pol_i;
         delay <= data_delay_i;
      end
   end

   // Lead-in, bit and character counters
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || take)
      begin
         lead_cnt <= '0;
         bit_cnt <= '0;
         char_cnt <= '0;
         lvl <= 1'b0;
      end
      else
      begin
         if (tick && (state == ST_LEAD))
            lead_cnt <= lead_cnt + 1'b1;
         if (char_end)
            bit_cnt <= '0;
         else if (trailing)
            bit_cnt <= bit_cnt + 1'b1;
         if (char_end && more)
            char_cnt <= char_cnt + 1'b1;
         lvl <= next_lvl;
      end
   end

   // Pins: clock and selects, idle levels follow the live settings
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         serial_clk_o <= 1'b0;
         slave_select_lines_o <= `SPM_CS_RST;
         busy_o <= 1'b0;
      end
      else
      begin
         if (next_state == ST_IDLE)
            serial_clk_o <= clock_polarity_select_i;
         else if (take)
            serial_clk_o <= clock_polarity_select_i;
         else
            serial_clk_o <= cpol ^ next_lvl;
         if (take)
            slave_select_lines_o <= cs_drive(slave_sel_i, select_pol_i, 1'b1);
         else if (next_state == ST_IDLE)
            slave_select_lines_o <= cs_drive(sel, select_pol_i, 1'b0);
         else
            slave_select_lines_o <= cs_drive(sel, pol, 1'b1);
         busy_o <= (next_state != ST_IDLE);
      end
   end

   // Character results; data leave only through these ports, never by DMA
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         rx_data_o <= '0;
         char_done_o <= 1'b0;
         char_irq_o <= 1'b0;
         frame_done_o <= 1'b0;
      end
      else
      begin
         if (char_end)
            rx_data_o <= sif.rx_word & (`SPM_ONES >> (5'h1f - len));
         char_done_o <= char_end;
         char_irq_o <= char_end && irq_en;
         frame_done_o <= (state == ST_TRAIL) && tick;
      end
   end

   // *****************************************************
   // Checks
   // *****************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   logic [`SPM_DIV_W:0] gap;
   logic [2:0] lead_ticks;
   logic [5:0] lead_edges;
   logic [5:0] samp_cnt;
   logic [`SPM_FRAME_W:0] chars_seen;
   wire [`SPM_CS_N-1:0] cs_act = ~(slave_select_lines_o ^ pol);

   // Helper counters seen only by the checks
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || state == ST_IDLE)
      begin
         gap <= '0;
         lead_ticks <= '0;
         chars_seen <= '0;
      end
      else
      begin
         gap <= tick ? 17'h00001 : gap + 1'b1;
         if (tick && state == ST_LEAD)
            lead_ticks <= lead_ticks + 1'b1;
         if (char_end)
            chars_seen <= chars_seen + 1'b1;
      end
      if (rst_i || sif.load)
      begin
         lead_edges <= '0;
         samp_cnt <= '0;
      end
      else
      begin
         if (leading)
            lead_edges <= lead_edges + 1'b1;
         if (do_sample)
            samp_cnt <= samp_cnt + 1'b1;
      end
   end

   a_tick_spacing: assert property (tick |-> gap == {1'b0, clk_div_i} + 17'h00001)
      else $error("serial clock half period wrong");
   a_clock_master: assert property (!busy_o && !$past(busy_o) |-> $stable(serial_clk_o)
      || $changed(clock_polarity_select_i) || $past($changed(clock_polarity_select_i)))
      else $error("serial clock moved outside a frame");
   a_bit_count: assert property (char_end |-> lead_edges == {1'b0, len} + 6'h01)
      else $error("wrong number of bits in a character");
   a_duplex_samples: assert property (char_end |-> samp_cnt + {5'h00, do_sample}
      == {1'b0, len} + 6'h01)
      else $error("receive bits do not match transmit bits");
   a_frame_chars: assert property (frame_done_o |-> $past(chars_seen) == {1'b0, frame_len}
      + 13'h0001)
      else $error("frame ended with wrong character count");
   a_lead_delay: assert property (state == ST_SHIFT && $past(state) == ST_LEAD |->
      lead_ticks == {delay, 1'b1})
      else $error("select to data delay wrong");
   a_one_select: assert property (busy_o && $past(busy_o) |-> cs_act == (4'h1 << sel))
      else $error("not exactly the chosen select active");
   a_select_release: assert property (frame_done_o |=> cs_act == 4'h0 || busy_o)
      else $error("select still active after frame");
   a_irq_gate: assert property (char_done_o |-> char_irq_o == irq_en)
      else $error("interrupt not gated by enable");
   a_loop_path: assert property (do_sample && loop |-> sif.rx_word[0] == serial_out_o)
      else $error("loopback bit not returned");
   a_clock_mode: assert property (state == ST_SHIFT && !lvl |-> serial_clk_o == cpol)
      else $error("clock not at idle level between edges");
   a_pol_level: assert property (state == ST_SHIFT |-> slave_select_lines_o[sel] == pol[sel])
      else $error("active select level wrong");

   c_two_chars: cover property (frame_done_o && chars_seen > 13'h0001);
   c_loopback: cover property (char_done_o && loop);
   c_mode3: cover property (char_done_o && cpol && cpha);
   c_irq: cover property (char_irq_o);
endmodule // spm_master

// [hdl/spm_cfg.svh]
// Constants for the master-only serial port
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

`define SPM_DATA_W 32
`define SPM_LEN_W 5
`define SPM_FRAME_W 12
`define SPM_DIV_W 16
`define SPM_CS_N 4
`define SPM_SEL_W 2
`define SPM_DLY_W 2
`define SPM_LEAD_W 3
`define SPM_CS_RST 4'hf
`define SPM_ONES 32'hffffffff

`endif

// [hdl/spm_pkg.sv]
// Types shared by the serial port modules
package spm_pkg;
   // *****************************************************
   // Frame sequencer states
   // *****************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TRAIL} spm_state_t;
endpackage

// [hdl/spm_shift_if.sv]
// Signals between the frame sequencer and the shift engine
`timescale 1ns/100ps
`include "spm_cfg.svh"
interface spm_shift_if;
   logic load;
   logic shift;
   logic sample;
   logic loopback;
   logic serial_in;
   logic [`SPM_DATA_W-1:0] load_data;
   logic [`SPM_LEN_W-1:0] char_len;
   logic tx_msb;
   logic [`SPM_DATA_W-1:0] rx_word;
   modport ctl (output load, shift, sample, loopback, serial_in, load_data, char_len,
                input tx_msb, rx_word);
   modport sh (input load, shift, sample, loopback, serial_in, load_data, char_len,
               output tx_msb, rx_word);
endinterface

// [hdl/spm_clk_div.sv]
// Bit-rate divider making a half-period enable pulse
`timescale 1ns/100ps
`include "spm_cfg.svh"
module spm_clk_div
   import spm_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic [`SPM_DIV_W-1:0] div_i,
   output logic tick_o
);
   logic [`SPM_DIV_W-1:0] cnt;
   wire wrap = (cnt == div_i);

   // Count restarts whenever the sequencer is idle so each frame starts clean
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || !run_i)
      begin
         cnt <= '0;
         tick_o <= 1'b0;
      end
      else
      begin
         cnt <= wrap ? '0 : cnt + 1'b1;
         tick_o <= wrap;
      end
   end
endmodule // spm_clk_div

// [hdl/spm_shifter.sv]
// Transmit and receive shift registers
`timescale 1ns/100ps
`include "spm_cfg.svh"
module spm_shifter
   import spm_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   spm_shift_if.sh sif
);
   logic [`SPM_DATA_W-1:0] tx_sr;
   logic [`SPM_DATA_W-1:0] rx_sr;
   wire rx_bit;
   wire [`SPM_LEN_W-1:0] align;

   // Loopback takes the outgoing bit instead of the pin
   assign rx_bit = sif.loopback ? tx_sr[`SPM_DATA_W-1] : sif.serial_in;
   assign align = 5'h1f - sif.char_len;
   assign sif.tx_msb = tx_sr[`SPM_DATA_W-1];
   // Received word including a sample taken in this very cycle
   assign sif.rx_word = sif.sample ? {rx_sr[`SPM_DATA_W-2:0], rx_bit} : rx_sr;

   // Load aligns the character MSB to the top; load wins over shift
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         tx_sr <= '0;
      else if (sif.load)
         tx_sr <= sif.load_data << align;
      else if (sif.shift)
         tx_sr <= {tx_sr[`SPM_DATA_W-2:0], 1'b0};
   end

   // Receive side shifts in alongside transmit
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         rx_sr <= '0;
      else if (sif.sample)
         rx_sr <= {rx_sr[`SPM_DATA_W-2:0], rx_bit};
   end
endmodule // spm_shifter

// [verification/spm_slave_model.sv]
// Behavioural serial slave that answers the master port
`timescale 1ns/100ps
module spm_slave_model (
   input wire logic sclk_i,
   input wire logic sel_i,
   input wire logic cpol_i,
   input wire logic cpha_i,
   input wire logic mosi_i,
   input wire logic [4:0] len_i,
   input wire logic [31:0] reply_i,
   output logic miso_o,
   output logic [31:0] got_o
);
   // ***************************************
   // Shift state
   // ***************************************
   int idx;
   logic lead;

   initial
   begin
      miso_o = 1'b0;
      got_o = '0;
      idx = 0;
   end

   // Frame start: phase 0 presents the first bit at once
   always @(posedge sel_i)
   begin
      idx = len_i;
      got_o = '0;
      if (!cpha_i)
         miso_o <= #1 reply_i[len_i];
   end

   // A released line shows the inverse of the last bit, not a held value
   always @(negedge sel_i)
      miso_o <= #1 ~miso_o;

   // Sample on one edge, shift on the other, only while selected
   always @(sclk_i)
   begin
      if (sel_i)
      begin
         lead = (sclk_i != cpol_i);
         if (lead != cpha_i)
            got_o = {got_o[30:0], mosi_i};
         else if (cpha_i)
         begin
            miso_o <= #1 reply_i[idx];
            idx = (idx == 0) ? int'(len_i) : idx - 1;
         end
         else
         begin
            idx = (idx == 0) ? int'(len_i) : idx - 1;
            miso_o <= #1 reply_i[idx];
         end
      end
   end
endmodule // spm_slave_model

// [verification/spi_master_port_tb.sv]
// Self-checking bench for the master-only serial port
`timescale 1ns/100ps
`include "spm_cfg.svh"
module spi_master_port_tb;
   import spm_pkg::*;
   typedef struct packed {
      logic cpol;
      logic cpha;
      logic [4:0] len;
      logic [11:0] frames;
      logic [1:0] sel;
      logic [3:0] pol;
      logic [1:0] dly;
      logic [15:0] div;
      logic irq_en;
      logic [31:0] tx;
      logic [31:0] reply;
      logic [7:0] gap;
   } spm_row_t;
   logic sys_clk_i, rst_i, start_i, cpol, cpha, loopback, irq_en;
   logic sclk, mosi, miso, char_done, char_irq, frame_done, busy, sel_act;
   logic [15:0] div;
   logic [4:0] len;
   logic [11:0] frames;
   logic [1:0] sel, dly;
   logic [3:0] pol, cs;
   logic [31:0] tx, reply, rx, got;
   int fail_count, num_checks, cyc;
   spm_row_t rows [5];

   spm_master uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(start_i), .clk_div_i(div),
      .char_len_i(len), .frame_len_i(frames), .slave_sel_i(sel), .select_pol_i(pol),
      .clock_polarity_select_i(cpol), .clock_phase_select_i(cpha), .data_delay_i(dly),
      .loopback_i(loopback), .char_irq_en_i(irq_en), .tx_data_i(tx), .serial_in_i(miso),
      .serial_clk_o(sclk), .serial_out_o(mosi), .slave_select_lines_o(cs), .rx_data_o(rx),
      .char_done_o(char_done), .char_irq_o(char_irq), .frame_done_o(frame_done),
      .busy_o(busy));

   assign sel_act = (cs[sel] === pol[sel]) && (busy === 1'b1);

   spm_slave_model slave (.sclk_i(sclk), .sel_i(sel_act), .cpol_i(cpol), .cpha_i(cpha),
      .mosi_i(mosi), .len_i(len), .reply_i(reply), .miso_o(miso), .got_o(got));

   // ***************************************
   // Clock and hang guard
   // ***************************************
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   always @(posedge sys_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         print_verdict;
      end
   end

   // ***************************************
   // Compare and verdict
   // ***************************************
   task check(input logic [31:0] got_v, input logic [31:0] exp_v);
      num_checks++;
      if (got_v !== exp_v)
      begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got_v, exp_v);
         fail_count++;
      end
   endtask

   task print_verdict;
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // One frame: configure, start, watch lead gap, characters and frame end
   task automatic run(input spm_row_t r, input logic lb, input int id);
      int n;
      int chars;
      logic [31:0] m;
      logic [3:0] act;
      m = 32'((64'h1 << (r.len + 1)) - 64'h1);
      act = ~r.pol ^ (4'h1 << r.sel);
      @(posedge sys_clk_i);
      #1;
      {cpol, cpha, len, frames, sel, pol, dly, div, irq_en} = r[115:72];
      tx = r.tx;
      reply = r.reply;
      loopback = lb;
      @(posedge sys_clk_i);
      #1 start_i = 1'b1;
      @(posedge sys_clk_i);
      #1 start_i = 1'b0;
      check({28'h0, cs}, {28'h0, act});
      n = 0;
      while (sclk === r.cpol && n < 2000)
      begin
         @(posedge sys_clk_i);
         #1 n++;
      end
      check(32'(n), {24'h0, r.gap});
      chars = 0;
      n = 0;
      while (frame_done !== 1'b1 && n < 20000)
      begin
         if (char_done === 1'b1)
         begin
            chars++;
            check(rx, (lb ? r.tx : r.reply) & m);
            check({31'h0, char_irq}, {31'h0, r.irq_en});
            check({28'h0, cs}, {28'h0, act});
         end
         @(posedge sys_clk_i);
         #1 n++;
      end
      check(32'(chars), {20'h0, r.frames} + 32'h1);
      if (!lb)
         check(got & m, r.tx & m);
      check({31'h0, sclk}, {31'h0, r.cpol});
      check({28'h0, cs}, {28'h0, ~r.pol});
      $display("test %0d done", id);
   endtask

   // ***************************************
   // Main sequence
   // ***************************************
   initial
   begin
      fail_count = 0;
      num_checks = 0;
      cyc = 0;
      rst_i = 1'b1;
      start_i = 1'b0;
      {cpol, cpha, loopback, irq_en} = 4'h0;
      {div, len, frames, sel, pol, dly} = '0;
      tx = '0;
      reply = '0;
      rows = '{
         '{1'h0, 1'h0, 5'h7, 12'h0, 2'h0, 4'h0, 2'h0, 16'h0, 1'h1, 32'ha5, 32'h3c, 8'h3},
         '{1'h0, 1'h1, 5'h1f, 12'h0, 2'h1, 4'h2, 2'h1, 16'h1, 1'h0, 32'h8badf00d,
           32'h1234567f, 8'h9},
         '{1'h1, 1'h0, 5'h0, 12'h2, 2'h2, 4'hf, 2'h2, 16'h2, 1'h1, 32'h0, 32'h1, 8'h13},
         '{1'h1, 1'h1, 5'hf, 12'h1, 2'h3, 4'h0, 2'h3, 16'h0, 1'h1, 32'hc3e1, 32'h5a0f, 8'h9},
         '{1'h0, 1'h0, 5'h4, 12'h0, 2'h0, 4'h1, 2'h0, 16'h3, 1'h0, 32'h13, 32'hc, 8'h9}};
      repeat (16) @(posedge sys_clk_i);
      #1 rst_i = 1'b0;
      check({28'h0, cs}, 32'hf);
      check({30'h0, busy, sclk}, 32'h0);
      $display("test reset done");
      foreach (rows[i])
         run(rows[i], 1'b0, i);
      run(rows[0], 1'b1, 5);
      // Reset in mid-frame: pins return to idle and the next frame still works
      @(posedge sys_clk_i);
      #1 start_i = 1'b1;
      @(posedge sys_clk_i);
      #1 start_i = 1'b0;
      repeat (5) @(posedge sys_clk_i);
      #1 rst_i = 1'b1;
      repeat (2) @(posedge sys_clk_i);
      #1 check({28'h0, cs}, 32'hf);
      check({30'h0, busy, sclk}, 32'h0);
      rst_i = 1'b0;
      @(posedge sys_clk_i);
      #1 check({30'h0, busy, sclk}, 32'h0);
      check({28'h0, cs}, 32'hf);
      $display("test mid reset done");
      run(rows[0], 1'b0, 6);
      print_verdict;
   end
endmodule // spi_master_port_tb
